// *** logic/ibc_byte_counter.sv ***
// Overview of operation
// - Writing the byte count register returns the buffer pointer to zero.
// - On sequence completion raise done and report bytes moved.
// - Transmit sends buffer bytes from location zero in load order.
// - Receive completion resets pointer so host reads start at first byte.
// - Master transmit count reads 1 after the address is sent.
// - Master transmit count reads n+1 after address plus n data bytes.
// - Arbitration lost in address with write gives count 0.
// - Arbitration lost at data byte n gives n, or n-1 after address interrupt.
// - Master receive raises no address interrupt; reports n after n bytes.
// - Master receive loss in address gives 0; in nth ack gives n.
// - Slave receive count reads 0 after own write address acknowledged.
// - Slave receive count reads n after n bytes received.
// - Slave transmit count reads 0 after own read address acknowledged.
// - Slave transmit count reads n after n bytes transmitted.
// - Count zero or above 68 moves no data; done follows control write.
// - Invalid count loads status with the illegal count code.
// - Buffer of 68 bytes wraps host writes back to location zero.
// - Last-byte flag makes the final received byte a not-acknowledge.
module ibc_byte_counter #(
  parameter int DEPTH = ibc_pkg::BUF_DEPTH
) (
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              count_wr_i,
  input  wire logic [7:0]        count_wdata_i,
  output logic      [7:0]        count_rdata_o,
  input  wire logic              data_wr_i,
  input  wire logic [7:0]        data_wdata_i,
  input  wire logic              data_rd_i,
  output logic      [7:0]        data_rdata_o,
  input  wire logic              ctrl_wr_i,
  input  wire ibc_pkg::ibc_kind_t kind_i,
  input  wire logic              addr_done_i,
  input  wire logic              addr_irq_i,
  input  wire logic              byte_done_i,
  input  wire logic [7:0]        rx_byte_i,
  input  wire logic              arb_lost_i,
  input  wire logic              stop_i,
  input  wire logic              nack_i,
  output logic      [7:0]        tx_byte_o,
  output logic                   ack_bit_o,
  output logic                   seq_done_o,
  output logic      [7:0]        status_code_o
);

  // ****************************************************************
  // Storage and state
  // ****************************************************************
  logic [7:0]          buf_mem [DEPTH];
  logic [6:0]          ptr_q;
  logic [6:0]          req_q;
  logic                lb_q;
  logic [6:0]          cnt_q;
  logic [7:0]          count_rdata_q;
  logic [7:0]          data_rdata_q;
  logic [7:0]          tx_byte_q;
  logic                ack_q;
  logic                done_q;
  logic                addr_irq_q;
  logic [7:0]          status_q;
  ibc_pkg::ibc_state_t state_q;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  wire logic [6:0] ptr_inc   = (ptr_q == 7'(DEPTH - 1)) ? ibc_pkg::PTR_FIRST
                                                       : ptr_q + 7'h01;
  wire logic       req_bad   = (req_q == ibc_pkg::CNT_ZERO) ||
                               (req_q > ibc_pkg::CNT_MAX);
  wire logic       is_tx     = (kind_i == ibc_pkg::IBC_MTX) ||
                               (kind_i == ibc_pkg::IBC_STX);
  wire logic       is_rx     = !is_tx;
  wire logic [6:0] cnt_inc   = cnt_q + 7'h01;
  wire logic       last_byte = (cnt_inc == req_q);
  wire logic       run       = (state_q == ibc_pkg::IBC_RUN);
  wire logic       host_wr   = data_wr_i && !run;
  wire logic       rx_wr     = run && is_rx && byte_done_i;
  wire logic       mtx_addr  = run && addr_done_i &&
                               (kind_i == ibc_pkg::IBC_MTX);
  // Address byte sits at buffer location zero in master transmit
  wire logic       ptr_fwd   = host_wr || data_rd_i || mtx_addr ||
                               (run && byte_done_i);
  wire logic       finish    = run && (stop_i || arb_lost_i || nack_i ||
                               (byte_done_i && last_byte) ||
                               (addr_done_i && kind_i == ibc_pkg::IBC_MTX &&
                                (addr_irq_i || last_byte)));
  // Count after an arbitration loss
  wire logic [6:0] arb_cnt   = (addr_irq_q && cnt_q != ibc_pkg::CNT_ZERO) ?
                               cnt_q - 7'h01 : cnt_q;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ibc_pkg::IBC_IDLE;
    end else if (ctrl_wr_i && !run) begin
      state_q <= req_bad ? ibc_pkg::IBC_DONE : ibc_pkg::IBC_RUN;
    end else if (finish) begin
      state_q <= ibc_pkg::IBC_DONE;
    end else if (state_q == ibc_pkg::IBC_DONE) begin
      state_q <= ibc_pkg::IBC_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (ctrl_wr_i && !run && req_bad) || finish;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_q <= ibc_pkg::STA_IDLE;
    end else if (ctrl_wr_i && !run && req_bad) begin
      status_q <= ibc_pkg::STA_BAD_COUNT;
    end else if (ctrl_wr_i && !run) begin
      status_q <= ibc_pkg::STA_IDLE;
    end
  end

  // ****************************************************************
  // Count register
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_q <= ibc_pkg::COUNT_RST[ibc_pkg::CNT_MSB:0];
      lb_q  <= 1'b0;
    end else if (count_wr_i) begin
      req_q <= count_wdata_i[ibc_pkg::CNT_MSB:0];
      lb_q  <= count_wdata_i[ibc_pkg::LB_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_irq_q <= 1'b0;
    end else if (ctrl_wr_i && !run) begin
      addr_irq_q <= 1'b0;
    end else if (run && addr_done_i && addr_irq_i) begin
      addr_irq_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= ibc_pkg::CNT_ZERO;
    end else if (ctrl_wr_i && !run) begin
      cnt_q <= ibc_pkg::CNT_ZERO;
    end else if (run && arb_lost_i) begin
      cnt_q <= arb_cnt;
    end else if (run && addr_done_i && kind_i == ibc_pkg::IBC_MTX) begin
      cnt_q <= cnt_inc;
    end else if (run && byte_done_i) begin
      cnt_q <= cnt_inc;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_rdata_q <= ibc_pkg::COUNT_RST;
    end else if (count_wr_i) begin
      count_rdata_q <= count_wdata_i;
    end else if (finish || state_q == ibc_pkg::IBC_DONE) begin
      count_rdata_q <= {lb_q, (run && arb_lost_i) ? arb_cnt :
                        (finish && !stop_i && !nack_i) ? cnt_inc : cnt_q};
    end
  end

  // ****************************************************************
  // Buffer pointer and memory
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_q <= ibc_pkg::PTR_FIRST;
    end else if (count_wr_i) begin
      ptr_q <= ibc_pkg::PTR_FIRST;
    end else if (finish || (ctrl_wr_i && !run && is_tx)) begin
      ptr_q <= ibc_pkg::PTR_FIRST;
    end else if (ptr_fwd) begin
      ptr_q <= ptr_inc;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (host_wr) begin
      buf_mem[ptr_q] <= data_wdata_i;
    end else if (rx_wr) begin
      buf_mem[ptr_q] <= rx_byte_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_rdata_q <= ibc_pkg::DATA_RST;
      tx_byte_q    <= ibc_pkg::DATA_RST;
    end else begin
      data_rdata_q <= buf_mem[ptr_q];
      tx_byte_q    <= buf_mem[ptr_q];
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b1;
    end else begin
      ack_q <= !(lb_q && last_byte && is_rx);
    end
  end

  assign count_rdata_o = count_rdata_q;
  assign data_rdata_o  = data_rdata_q;
  assign tx_byte_o     = tx_byte_q;
  assign ack_bit_o     = ack_q;
  assign seq_done_o    = done_q;
  assign status_code_o = status_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_ptr_reset;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    count_wr_i |=> (ptr_q == ibc_pkg::PTR_FIRST);
  endproperty
  a_ptr_reset: assert property (p_ptr_reset)
    else $error("pointer not reset by count write");

  property p_bad_done;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (ctrl_wr_i && !run && req_bad) |=> seq_done_o &&
      (status_code_o == ibc_pkg::STA_BAD_COUNT);
  endproperty
  a_bad_done: assert property (p_bad_done)
    else $error("invalid count did not finish at once");

  property p_bad_nodata;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (ctrl_wr_i && !run && req_bad) |=> !run;
  endproperty
  a_bad_nodata: assert property (p_bad_nodata)
    else $error("invalid count started a transfer");

  property p_done_ptr;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (finish && !count_wr_i) |=> (ptr_q == ibc_pkg::PTR_FIRST);
  endproperty
  a_done_ptr: assert property (p_done_ptr)
    else $error("pointer not rewound at completion");

  property p_done_count;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (finish && byte_done_i && !arb_lost_i && !stop_i && !nack_i
     && !count_wr_i) |=> (count_rdata_o[6:0] == $past(cnt_inc));
  endproperty
  a_done_count: assert property (p_done_count)
    else $error("count not reported at completion");

  property p_mtx_addr;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (run && addr_done_i && kind_i == ibc_pkg::IBC_MTX && !arb_lost_i &&
     cnt_q == ibc_pkg::CNT_ZERO && !ctrl_wr_i) |=> (cnt_q == 7'h01);
  endproperty
  a_mtx_addr: assert property (p_mtx_addr)
    else $error("address not counted");

  property p_wrap;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (host_wr && !count_wr_i && ptr_q == 7'(DEPTH - 1))
      |=> (ptr_q == ibc_pkg::PTR_FIRST);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("buffer pointer did not wrap");

  property p_lb_nack;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (lb_q && last_byte && is_rx && !count_wr_i) |=> !ack_bit_o;
  endproperty
  a_lb_nack: assert property (p_lb_nack)
    else $error("last byte not refused");

  property p_arb_addr;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (run && arb_lost_i && cnt_q == ibc_pkg::CNT_ZERO && !ctrl_wr_i)
      |=> (cnt_q == ibc_pkg::CNT_ZERO);
  endproperty
  a_arb_addr: assert property (p_arb_addr)
    else $error("count moved on address arbitration loss");

  property p_count_load;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    count_wr_i |=> (count_rdata_o == $past(count_wdata_i));
  endproperty
  a_count_load: assert property (p_count_load)
    else $error("count register write not held");

  property p_tx_order;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (run && is_tx && byte_done_i && !finish && !count_wr_i)
      |=> (ptr_q == $past(ptr_inc));
  endproperty
  a_tx_order: assert property (p_tx_order)
    else $error("transmit pointer did not step");

  property p_tx_start;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (ctrl_wr_i && !run && is_tx && !count_wr_i)
      |=> (ptr_q == ibc_pkg::PTR_FIRST);
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("transmit did not start at first byte");

  property p_rx_store;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rx_wr |=> (buf_mem[$past(ptr_q)] == $past(rx_byte_i));
  endproperty
  a_rx_store: assert property (p_rx_store)
    else $error("received byte not stored");

  property p_byte_count;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (run && byte_done_i && !arb_lost_i) |=> (cnt_q == $past(cnt_inc));
  endproperty
  a_byte_count: assert property (p_byte_count)
    else $error("byte not counted");

  property p_good_start;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (ctrl_wr_i && !run && !req_bad)
      |=> run && (status_code_o == ibc_pkg::STA_IDLE);
  endproperty
  a_good_start: assert property (p_good_start)
    else $error("valid count did not start a transfer");

  property p_ack_all;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    !lb_q |=> ack_bit_o;
  endproperty
  a_ack_all: assert property (p_ack_all)
    else $error("byte refused with last-byte flag clear");

endmodule

// *** logic/ibc_pkg.sv ***
package ibc_pkg;
  // ****************************************************************
  // Buffer and count layout
  // ****************************************************************
  localparam int          BUF_DEPTH      = 68;
  localparam int          PTR_W          = 7;
  localparam int          CNT_MSB        = 6;
  localparam int          LB_BIT         = 7;
  localparam logic [6:0]  CNT_MAX        = 7'h44;
  localparam logic [6:0]  CNT_ZERO       = 7'h00;
  localparam logic [6:0]  PTR_FIRST      = 7'h00;
  localparam logic [7:0]  COUNT_RST      = 8'h00;
  localparam logic [7:0]  STA_BAD_COUNT  = 8'hFC;
  localparam logic [7:0]  STA_IDLE       = 8'hF8;
  localparam logic [7:0]  DATA_RST       = 8'h00;

  // ****************************************************************
  // Sequence kinds
  // ****************************************************************
  typedef enum logic [1:0] {
    IBC_MTX,
    IBC_MRX,
    IBC_STX,
    IBC_SRX
  } ibc_kind_t;

  typedef enum {
    IBC_IDLE,
    IBC_RUN,
    IBC_DONE
  } ibc_state_t;
endpackage

// *** verif/ibc_bus_model.sv ***
module ibc_bus_model (
  input  wire logic       ref_clk_i,
  output logic            addr_done_o,
  output logic            addr_irq_o,
  output logic            byte_done_o,
  output logic [7:0]      rx_byte_o,
  output logic            arb_lost_o,
  output logic            stop_o,
  output logic            nack_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Bus engine events
  // ****************************************************************
  initial begin
    {addr_done_o, addr_irq_o, byte_done_o} = 3'h0;
    {arb_lost_o, stop_o, nack_o} = 3'h0;
    rx_byte_o = 8'h00;
  end

  // Codes 0 addr, 1 byte, 2 nack, 3 arb loss, 4 stop
  task automatic ev(input logic [2:0] e, input logic [7:0] d,
                    input logic irq);
    @(posedge ref_clk_i);
    addr_done_o <= (e == 3'h0);
    addr_irq_o  <= irq;
    byte_done_o <= (e == 3'h1);
    nack_o      <= (e == 3'h2);
    arb_lost_o  <= (e == 3'h3);
    stop_o      <= (e == 3'h4);
    rx_byte_o   <= d;
    @(posedge ref_clk_i);
    {addr_done_o, byte_done_o, nack_o, arb_lost_o, stop_o} <= 5'h00;
    rx_byte_o   <= ~d;
    @(posedge ref_clk_i);
  endtask
endmodule

// *** verif/i2c_buffer_byte_counter_bench.sv ***
module i2c_buffer_byte_counter_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic               ref_clk;
  logic               nrst;
  logic               count_wr;
  logic               data_wr;
  logic               data_rd;
  logic               ctrl_wr;
  logic [7:0]         count_wdata;
  logic [7:0]         data_wdata;
  ibc_pkg::ibc_kind_t kind;
  logic               addr_done, addr_irq, byte_done, arb_lost, stop, nack;
  logic [7:0]         rx_byte, count_rdata, data_rdata, tx_byte, status;
  logic               ack_bit, seq_done, done_seen;
  logic [7:0]         ref_q [68];
  logic [7:0]         got_q [68];
  logic [7:0]         bad [3] = '{8'h00, 8'h45, 8'hFF};
  logic [7:0]         d;
  int                 err_total, compares, seed = 32'h4A1A;
  int                 it, i, j, k, m, kd, tm, adr, irq, lb, w, full;

  ibc_byte_counter i_dut (
    .ref_clk_i(ref_clk), .nrst_i(nrst), .count_wr_i(count_wr),
    .count_wdata_i(count_wdata), .count_rdata_o(count_rdata),
    .data_wr_i(data_wr), .data_wdata_i(data_wdata), .data_rd_i(data_rd),
    .data_rdata_o(data_rdata), .ctrl_wr_i(ctrl_wr), .kind_i(kind),
    .addr_done_i(addr_done), .addr_irq_i(addr_irq),
    .byte_done_i(byte_done), .rx_byte_i(rx_byte), .arb_lost_i(arb_lost),
    .stop_i(stop), .nack_i(nack), .tx_byte_o(tx_byte),
    .ack_bit_o(ack_bit), .seq_done_o(seq_done), .status_code_o(status)
  );

  ibc_bus_model i_bus (
    .ref_clk_i(ref_clk), .addr_done_o(addr_done), .addr_irq_o(addr_irq),
    .byte_done_o(byte_done), .rx_byte_o(rx_byte),
    .arb_lost_o(arb_lost), .stop_o(stop), .nack_o(nack)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) if (seq_done === 1'b1) done_seen <= 1'b1;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic tally_and_finish;
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobes: 0 count, 1 data write, 2 data read, 3 control
  task automatic hit(input int s, input logic [7:0] v);
    @(posedge ref_clk);
    count_wr    <= (s == 0);
    data_wr     <= (s == 1);
    data_rd     <= (s == 2);
    ctrl_wr     <= (s == 3);
    count_wdata <= v;
    data_wdata  <= v;
    @(posedge ref_clk);
    {count_wr, data_wr, data_rd, ctrl_wr} <= 4'h0;
    @(posedge ref_clk);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (done_seen !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (done_seen !== 1'b1) begin
      cmp({7'h00, done_seen}, 8'h01);
      tally_and_finish;
    end
    repeat (2) @(posedge ref_clk);
  endtask

  function automatic logic [7:0] exp_cnt(int kd, int adr, int irq, int m,
                                         int tm);
    if (kd != 0) return 8'(m);
    return 8'(adr + m - ((tm == 2 && irq == 1) ? adr : 0));
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    {count_wr, data_wr, data_rd, ctrl_wr} = 4'h0;
    count_wdata = 8'h00;
    data_wdata = 8'h00;
    kind = ibc_pkg::IBC_MTX;
    done_seen = 1'b0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (bad[b]) begin
      hit(0, bad[b]);
      done_seen = 1'b0;
      hit(3, 8'h00);
      wait_done;
      cmp(status, ibc_pkg::STA_BAD_COUNT);
    end
    for (it = 0; it < 40; it++) begin
      kd = (it < 4) ? it : $unsigned($random(seed)) % 4;
      k = (it == 1) ? 68 : 1 + $unsigned($random(seed)) % 68;
      tm = (it < 4) ? 0 : $unsigned($random(seed)) % 4;
      lb = $unsigned($random(seed)) % 2;
      irq = (kd == 0) ? $unsigned($random(seed)) % 2 : 0;
      full = (kd == 0) ? k - 1 : k;
      if (full == 0) tm = 0;
      adr = (kd < 2) ? 1 : 0;
      if (tm == 2 && kd < 2 && $random(seed) % 2 != 0) adr = 0;
      m = (tm == 0) ? full : $unsigned($random(seed)) % full;
      if (kd < 2 && adr == 0) m = 0;
      if (tm != 0) irq = 0;
      if (irq == 1) m = 0;
      hit(0, 8'hFF);
      for (i = 0; i < 3; i++) hit(1, 8'hA5);
      hit(0, {1'(lb), 7'(k)});
      w = (kd % 2 == 1) ? 0 : ((it == 2) ? k + 68 : k);
      for (i = 0; i < w; i++) begin
        d = 8'($random(seed));
        ref_q[i % 68] = d;
        hit(1, d);
      end
      kind <= ibc_pkg::ibc_kind_t'(2'(kd));
      done_seen = 1'b0;
      hit(3, 8'h00);
      for (j = 0; j < adr + m; j++) begin
        #1;
        if (kd % 2 == 0) cmp(tx_byte, ref_q[j]);
        if (kd % 2 == 1 && j >= adr)
          cmp({7'h00, ack_bit}, {7'h00, !(lb == 1 && j - adr == k - 1)});
        d = 8'($random(seed));
        if (j >= adr) got_q[j - adr] = d;
        i_bus.ev((j < adr) ? 3'h0 : 3'h1, d, 1'(irq));
      end
      if (tm != 0) i_bus.ev(3'(tm + 1), 8'h00, 1'b0);
      wait_done;
      cmp({1'b0, count_rdata[6:0]}, exp_cnt(kd, adr, irq, m, tm));
      cmp({7'h00, count_rdata[7]}, 8'(lb));
      for (i = 0; i < m && kd % 2 == 1; i++) begin
        #1;
        cmp(data_rdata, got_q[i]);
        hit(2, 8'h00);
      end
    end
    tally_and_finish;
  end
endmodule
